// *** include/pll_switch_pkg.sv ***
// Constants, enumerations and carrier structs of the reference switchover block.
// Assumes a single core clock; reference inputs arrive as synchronous samples.
package pll_switch_pkg;

	// Register byte offsets on the AXI4-Lite slave
	localparam int unsigned ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_LIMIT = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

	// Field positions and reset values
	localparam int unsigned LIMIT_W = 16;
	localparam int unsigned CTRL_AUTO_BIT = 0;
	localparam int unsigned STAT_PRI_BIT = 0;
	localparam int unsigned STAT_BAK_BIT = 1;
	localparam int unsigned STAT_ACT_BIT = 2;
	localparam int unsigned STAT_FSM_LSB = 3;
	localparam logic CTRL_AUTO_RST = 1'b1;
	localparam logic [LIMIT_W-1:0] LIMIT_RST = 16'h0010;

	// Bus response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Switchover sequence, Gray coded along run -> gate -> new; new -> run flips both bits
	typedef enum logic [1:0] {
		SW_RUN = 2'h0,
		SW_GATE = 2'h1,
		SW_NEW = 2'h3
	} sw_state_t;

	// AXI4-Lite request and response bundles
	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;

	// State of one clock-sense channel
	typedef struct packed {
		logic prev;
		logic [LIMIT_W-1:0] cnt;
		logic lost;
	} sense_state_t;

	// State of the multiplexer output stage
	typedef struct packed {
		logic out;
	} mux_state_t;

	// State of the top level: sequencer plus register slave
	typedef struct packed {
		sw_state_t fsm;
		logic active;
		logic gate;
		logic sw_prev;
		logic auto_en;
		logic [LIMIT_W-1:0] limit;
		logic aw_got;
		logic [ADDR_W-1:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} top_state_t;

	localparam top_state_t TOP_RST = '{
		fsm: SW_RUN,
		active: 1'b0,
		gate: 1'b1,
		auto_en: CTRL_AUTO_RST,
		limit: LIMIT_RST,
		default: '0
	};

endpackage : pll_switch_pkg

// *** src/ref_clock_sense.sv ***
// Clock-sense channel: flags a reference input that has stopped toggling.
// Assumes the reference is sampled synchronously to the core clock.
`timescale 1ns/10ps
module ref_clock_sense
	import pll_switch_pkg::*;
(
	// Clock, reset, enable
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Sampled reference and quiet limit in core cycles
	input wire logic ref_i,
	input wire logic [LIMIT_W-1:0] limit_i,
	// Falling edge pulse and loss flag
	output logic fall_o,
	output logic lost_o
);

	sense_state_t q;
	sense_state_t d;
	logic toggle;

	// Edge detection against the previous sample
	assign toggle = ref_i ^ q.prev;
	assign fall_o = q.prev & ~ref_i;
	assign lost_o = q.lost;

	// Count quiet cycles; the flag drops on the first edge seen again
	always_comb
	begin
		d = q;
		d.prev = ref_i;
		if (toggle)
		begin
			d.cnt = '0;
			d.lost = 1'b0;
		end
		else
		begin
			if (q.cnt != '1)
				d.cnt = q.cnt + 1'b1; // Saturates so a dead clock stays flagged
			if (q.cnt >= limit_i - 1'b1)
				d.lost = 1'b1;
		end
	end

	// State register
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
			q <= '0;
		else if (ce_i)
			q <= d;
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	a_loss_set: assert property (ce_i && !toggle && q.cnt >= limit_i - 1'b1 |=> lost_o)
		else $error("quiet reference not flagged lost");
	a_loss_clear: assert property (ce_i && toggle |=> !lost_o)
		else $error("toggling reference flagged lost");

endmodule : ref_clock_sense

// *** src/ref_glitch_mux.sv ***
// Registered reference multiplexer with a gate that forces the output low.
// Assumes gate and select change only while the chosen input is low.
`timescale 1ns/10ps
module ref_glitch_mux
	import pll_switch_pkg::*;
(
	// Clock, reset, enable
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Sampled references and control
	input wire logic primary_i,
	input wire logic backup_i,
	input wire logic sel_backup_i,
	input wire logic gate_i,
	// Multiplexed reference
	output logic mux_o
);

	mux_state_t q;
	mux_state_t d;

	// A closed gate holds the output low, so no runt pulse escapes a switch
	always_comb
	begin
		d = q;
		d.out = gate_i & (sel_backup_i ? backup_i : primary_i);
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
			q <= '0;
		else if (ce_i)
			q <= d;
	end

	assign mux_o = q.out;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	a_gate_quiet: assert property (ce_i && !gate_i |=> !mux_o)
		else $error("gated multiplexer output not low");
	a_mux_follow: assert property (ce_i && gate_i && sel_backup_i |=> mux_o == $past(backup_i))
		else $error("multiplexer output does not follow backup");

endmodule : ref_glitch_mux

// *** src/pll_ref_clock_switchover.sv ***
// Reference switchover front end: clock sense, switch sequencer, register slave.
// Assumes references and the manual switch are synchronous to core_clk_i.
// Behaviour
// - Auto-switch to other input on clock loss
// - Export two lost flags and active indicator
// - Auto switching repeats without any count limit
// - Flag input lost after about two quiet periods
// - Sequencer drives multiplexer select on loss
// - Switch takes effect on available input's fall
// - Manual rising edge starts the switch sequence
// - Gate counter reference on current input's fall
// - On target fall route it, update indicator
// - Indicator follows manual switch; flags stay clear
// - Only rising edge acts; each repeats sequence
// - Wait until the target input toggles
// - Switch held high blocks further switching
// - Pure manual mode uses the same sequence
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module pll_ref_clock_switchover
	import pll_switch_pkg::*;
(
	// Clock, reset, enable
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Reference inputs and manual switch
	input wire logic primary_ref_in_i,
	input wire logic backup_ref_in_i,
	input wire logic manual_switch_i,
	// Multiplexed reference and status
	output logic ref_mux_o,
	output logic primary_ref_lost_o,
	output logic backup_ref_lost_o,
	output logic active_backup_o,
	// AXI4-Lite register slave
	input wire axil_req_t axil_req_i,
	output axil_rsp_t axil_rsp_o
);

	top_state_t q;
	top_state_t d;
	logic [1:0] refs;
	logic [1:0] fall;
	logic [1:0] lost;
	logic cur_lost;
	logic oth_lost;
	logic cur_fall;
	logic tgt_fall;
	logic sw_rise;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;

	// One sense channel per reference; index 1 is the backup.
	// Both channels share one quiet limit, so references far apart in frequency
	// cannot both be judged fairly: such pairs must be switched by hand.
	assign refs = {backup_ref_in_i, primary_ref_in_i};

	for (genvar i = 0; i < 2; i++)
	begin : g_sense
		ref_clock_sense u_sense (
			.core_clk_i(core_clk_i),
			.rstn_i(rstn_i),
			.ce_i(ce_i),
			.ref_i(refs[i]),
			.limit_i(q.limit),
			.fall_o(fall[i]),
			.lost_o(lost[i])
		);
	end

	// Output stage follows the sequencer's select and gate
	ref_glitch_mux u_mux (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.primary_i(primary_ref_in_i),
		.backup_i(backup_ref_in_i),
		.sel_backup_i(q.active),
		.gate_i(q.gate),
		.mux_o(ref_mux_o)
	);

	// Views relative to the input now in use and the one to switch to
	// Falls come from the live sample, so a switch lands on the edge that shows it
	assign cur_lost = q.active ? lost[1] : lost[0];
	assign oth_lost = q.active ? lost[0] : lost[1];
	assign cur_fall = q.active ? fall[1] : fall[0];
	assign tgt_fall = q.active ? fall[0] : fall[1];
	assign sw_rise = manual_switch_i & ~q.sw_prev;

	// Status outputs
	assign primary_ref_lost_o = lost[0];
	assign backup_ref_lost_o = lost[1];
	assign active_backup_o = q.active;

	// Bus readiness; a frozen block accepts nothing
	// Holding bvalid keeps both write halves out, so one write is in flight
	assign axil_rsp_o.awready = ce_i & ~q.aw_got & ~q.bvalid;
	assign axil_rsp_o.wready = ce_i & ~q.w_got & ~q.bvalid;
	assign axil_rsp_o.arready = ce_i & ~q.rvalid;
	assign axil_rsp_o.bvalid = q.bvalid;
	assign axil_rsp_o.bresp = q.bresp;
	assign axil_rsp_o.rvalid = q.rvalid;
	assign axil_rsp_o.rdata = q.rdata;
	assign axil_rsp_o.rresp = q.rresp;
	assign aw_hs = axil_req_i.awvalid & axil_rsp_o.awready;
	assign w_hs = axil_req_i.wvalid & axil_rsp_o.wready;
	assign ar_hs = axil_req_i.arvalid & axil_rsp_o.arready;

	// Register readback; unused bits read as zero
	function automatic logic [32:0] read_word(input logic [ADDR_W-1:0] addr,
		input top_state_t s, input logic [1:0] lst);
		logic [31:0] w;
		logic ok;
		w = '0;
		ok = 1'b1;
		unique case (addr)
			OFS_CTRL: w[CTRL_AUTO_BIT] = s.auto_en;
			OFS_LIMIT: w[LIMIT_W-1:0] = s.limit;
			OFS_STATUS:
			begin
				w[STAT_PRI_BIT] = lst[0];
				w[STAT_BAK_BIT] = lst[1];
				w[STAT_ACT_BIT] = s.active;
				w[STAT_FSM_LSB +: 2] = s.fsm;
			end
			default: ok = 1'b0;
		endcase
		return {ok, w};
	endfunction : read_word

	// Next state: switch sequencer and register slave
	always_comb
	begin
		logic [32:0] rd;
		rd = '0;
		d = q;
		d.sw_prev = manual_switch_i;
		unique case (q.fsm)
			SW_RUN:
			begin
				if (sw_rise)
				begin
					// Manual edge overrides automatic selection
					if (cur_lost)
					begin
						d.gate = 1'b0;
						d.fsm = SW_NEW;
					end
					else
						d.fsm = SW_GATE;
				end
				else if (q.auto_en && !manual_switch_i && cur_lost && !oth_lost)
				begin
					// A dead clock gives no fall to wait on, so gate at once
					d.gate = 1'b0;
					d.fsm = SW_NEW;
				end
			end
			SW_GATE:
			begin
				// A current input that dies while waiting gives no fall, so stop waiting
				if (cur_fall || cur_lost)
				begin
					d.gate = 1'b0;
					d.fsm = SW_NEW;
				end
			end
			SW_NEW:
			begin
				// Target must be toggling; otherwise stay here
				if (tgt_fall && !oth_lost)
				begin
					d.active = ~q.active;
					d.gate = 1'b1;
					d.fsm = SW_RUN;
				end
			end
			default:
			begin
				// Illegal code: park gated and wait for a clean target fall
				d.gate = 1'b0;
				d.fsm = SW_NEW;
			end
		endcase

		// Write channel: address and data in either order
		if (aw_hs)
		begin
			d.aw_got = 1'b1;
			d.awaddr = axil_req_i.awaddr;
		end
		if (w_hs)
		begin
			d.w_got = 1'b1;
			d.wdata = axil_req_i.wdata;
			d.wstrb = axil_req_i.wstrb;
		end
		if (q.aw_got && q.w_got && !q.bvalid)
		begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			unique case (q.awaddr)
				OFS_CTRL:
				begin
					if (q.wstrb[0])
						d.auto_en = q.wdata[CTRL_AUTO_BIT];
				end
				OFS_LIMIT:
				begin
					for (int b = 0; b < LIMIT_W / 8; b++)
					begin
						if (q.wstrb[b])
							d.limit[8*b +: 8] = q.wdata[8*b +: 8];
					end
				end
				OFS_STATUS: d.bresp = RESP_OKAY; // Read-only, write ignored
				default: d.bresp = RESP_SLVERR;
			endcase
		end
		else if (q.bvalid && axil_req_i.bready)
			d.bvalid = 1'b0;

		// Read channel: answer one cycle after the address is taken
		// Status is read live, so a flag may move between two reads
		if (ar_hs)
		begin
			rd = read_word(axil_req_i.araddr, q, lost);
			d.rvalid = 1'b1;
			d.rdata = rd[31:0];
			d.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
		end
		else if (q.rvalid && axil_req_i.rready)
			d.rvalid = 1'b0;
	end

	// State register; enable low freezes everything
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
			q <= TOP_RST;
		else if (ce_i)
			q <= d;
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	// Multi-step sequences of the manual switch
	sequence s_manual_rise;
		ce_i && q.fsm == SW_RUN && sw_rise && !cur_lost;
	endsequence

	sequence s_gate_off;
		ce_i && q.fsm == SW_GATE && cur_fall;
	endsequence

	sequence s_target_fall;
		ce_i && q.fsm == SW_NEW && tgt_fall && !oth_lost;
	endsequence

	// Properties of the switch sequencer

	a_auto_loss_switch: assert property (ce_i && q.fsm == SW_RUN && q.auto_en && !sw_rise
		&& !manual_switch_i && cur_lost && !oth_lost |=> q.fsm == SW_NEW && !q.gate)
		else $error("automatic switch not started on clock loss");
	a_manual_start: assert property (s_manual_rise |=> q.fsm == SW_GATE && q.gate)
		else $error("manual edge did not start the sequence");
	a_gate_on_fall: assert property (s_gate_off |=> !q.gate ##0 q.fsm == SW_NEW)
		else $error("reference not gated on current fall");
	a_switch_on_fall: assert property (s_target_fall |=> q.fsm == SW_RUN && q.gate)
		else $error("switch not completed on target fall");
	a_active_change: assert property ($changed(q.active)
		|-> $past(q.fsm) == SW_NEW && $past(tgt_fall))
		else $error("indicator changed outside target fall");
	a_no_fall_return: assert property (ce_i && q.fsm == SW_RUN && !manual_switch_i
		&& q.sw_prev && !q.auto_en |=> q.fsm == SW_RUN && $stable(q.active))
		else $error("falling switch edge changed the selection");
	a_wait_target: assert property (ce_i && q.fsm == SW_NEW && oth_lost
		|=> q.fsm == SW_NEW && $stable(q.active))
		else $error("switched to a dead input");
	a_block_high: assert property (ce_i && q.fsm == SW_RUN && manual_switch_i && q.sw_prev
		|=> q.fsm == SW_RUN)
		else $error("switch started while manual input held high");
	a_full_manual: assert property (ce_i && q.fsm == SW_RUN && !q.auto_en && !sw_rise
		|=> q.fsm == SW_RUN)
		else $error("pure manual mode switched without an edge");
	a_mux_gated: assert property (ce_i && q.fsm == SW_NEW |=> !ref_mux_o)
		else $error("reference not held low while switching");
	a_hold_select: assert property (ce_i && q.fsm != SW_NEW |=> $stable(q.active))
		else $error("selection changed outside a target fall");

endmodule : pll_ref_clock_switchover

// *** bench/ref_clk_model.sv ***
// Behavioural reference clock source facing the switchover block.
// Assumes a core clock much faster than the reference it makes.
`timescale 1ns/10ps
module ref_clk_model
#(
	parameter int HALF = 6
)
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Run control and reference out
	input wire logic run_i,
	output logic ref_o
);
	int cnt_q;

	// Stopping freezes the level, so a dead source looks stuck, not idle
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			cnt_q <= 0;
			ref_o <= 1'b0;
		end
		else if (run_i && cnt_q == HALF - 1)
		begin
			cnt_q <= 0;
			ref_o <= ~ref_o;
		end
		else if (run_i)
			cnt_q <= cnt_q + 1;
	end
endmodule : ref_clk_model

// *** bench/testbench.sv ***
// Self-checking bench: two reference sources, manual switch, register reads.
// Assumes the design answers reads on AXI4-Lite and holds STATUS at 0x8.
`timescale 1ns/10ps
module testbench
	import pll_switch_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic pri_run = 1'b1;
	logic bak_run = 1'b1;
	logic manual_sw = 1'b0;
	axil_req_t req = '0;
	axil_rsp_t rsp;
	logic pri_ref;
	logic bak_ref;
	logic ref_mux;
	logic pri_lost;
	logic bak_lost;
	logic act_bak;
	int error_cnt = 0;
	int checks_done = 0;
	logic [33:0] exp_q[$];
	logic [15:0] lim;
	logic ce = 1'b1;
	logic act_seen = 1'b0;
	logic pll_rst = 1'b0;
	logic pfd_en = 1'b1;
	logic out_en = 1'b1;
	int sw_cnt = 0;

	always #12.5 core_clk = ~core_clk;

	// Sources 12 and 14 core cycles long stay within the sensing margin
	ref_clk_model #(.HALF(6)) i_pri (.core_clk_i(core_clk), .rstn_i(rst_n), .run_i(pri_run),
		.ref_o(pri_ref));
	ref_clk_model #(.HALF(7)) i_bak (.core_clk_i(core_clk), .rstn_i(rst_n), .run_i(bak_run),
		.ref_o(bak_ref));

	pll_ref_clock_switchover i_dut (.core_clk_i(core_clk), .rstn_i(rst_n), .ce_i(ce),
		.primary_ref_in_i(pri_ref), .backup_ref_in_i(bak_ref), .manual_switch_i(manual_sw),
		.ref_mux_o(ref_mux), .primary_ref_lost_o(pri_lost), .backup_ref_lost_o(bak_lost),
		.active_backup_o(act_bak), .axil_req_i(req), .axil_rsp_o(rsp));

	task chk(input string name, input logic [33:0] seen, input logic [33:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value %s exp %h seen %h", name, exp, seen);
		end
	endtask : chk

	task final_report;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	task hang(input string name);
		error_cnt++;
		$display("wrong value %s exp 1 seen 0", name);
		final_report();
	endtask : hang

	task tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick

	function automatic logic [31:0] stat(input logic p, input logic b, input logic a);
		return {29'h0, a, b, p};
	endfunction : stat

	// Address and data offered together; each half dropped once taken
	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		bit aw_ok;
		bit w_ok;
		int n;
		aw_ok = 0;
		w_ok = 0;
		n = 0;
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		while (!(aw_ok && w_ok) && n < 100)
		begin
			@(posedge core_clk);
			n++;
			if (rsp.awready === 1'b1 && !aw_ok)
			begin
				aw_ok = 1;
				req.awvalid <= 1'b0;
			end
			if (rsp.wready === 1'b1 && !w_ok)
			begin
				w_ok = 1;
				req.wvalid <= 1'b0;
			end
		end
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (rsp.bvalid !== 1'b1 && n < 100);
		req.bready <= 1'b0;
		if (n >= 100)
			hang("write answer");
		@(posedge core_clk);
	endtask : wr

	// The expected word is noted before the request goes out
	task rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		exp_q.push_back({r, d});
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (rsp.arready !== 1'b1 && n < 100);
		req.arvalid <= 1'b0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (rsp.rvalid !== 1'b1 && n < 100);
		req.rready <= 1'b0;
		if (n >= 100)
			hang("read answer");
		@(posedge core_clk);
	endtask : rd

	// Multiplexed output must repeat the chosen input one cycle late
	task mux_follow(input logic use_bak, input int n);
		logic prev;
		prev = use_bak ? bak_ref : pri_ref;
		repeat (n)
		begin
			@(posedge core_clk);
			chk("mux out", {33'h0, ref_mux}, {33'h0, prev});
			prev = use_bak ? bak_ref : pri_ref;
		end
	endtask : mux_follow

	task wait_act(input logic v);
		int n;
		n = 0;
		while (act_bak !== v && n < 800)
		begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 800)
			hang("active change");
	endtask : wait_act

	// User logic: reset pulse per switch, oscillator hold and output enable from status
	always @(posedge core_clk)
	begin
		if (rst_n === 1'b1)
		begin
			act_seen <= act_bak;
			pll_rst <= (act_bak !== act_seen);
			pfd_en <= !(pri_lost || bak_lost);
			out_en <= pfd_en && !pll_rst;
			if (act_bak !== act_seen)
				sw_cnt++;
		end
	end

	// Each accepted read is matched against the oldest noted expectation
	always @(posedge core_clk)
	begin
		if (rsp.rvalid === 1'b1 && req.rready === 1'b1)
		begin
			if (exp_q.size() > 0)
				chk("read word", {rsp.rresp, rsp.rdata}, exp_q.pop_front());
			else
				hang("noted read");
		end
	end

	initial
	begin
		void'($urandom(29));
		tick(5);
		rst_n <= 1'b1;
		tick(1);
		// Reset values, unmapped offset, read-only status
		rd(OFS_CTRL, 32'h1, RESP_OKAY);
		rd(OFS_LIMIT, 32'h10, RESP_OKAY);
		rd(OFS_STATUS, stat(0, 0, 0), RESP_OKAY);
		rd(4'hc, 32'h0, RESP_SLVERR);
		lim = 16'h14 + 16'($urandom % 8);
		wr(OFS_LIMIT, {16'h0, lim});
		wr(OFS_STATUS, 32'h1f);
		rd(OFS_LIMIT, {16'h0, lim}, RESP_OKAY);
		rd(OFS_STATUS, stat(0, 0, 0), RESP_OKAY);
		$display("test registers done");
		// Primary dies, then backup dies: selection moves each time
		pri_run <= 1'b0;
		wait_act(1'b1);
		rd(OFS_STATUS, stat(1, 0, 1), RESP_OKAY);
		pri_run <= 1'b1;
		bak_run <= 1'b0;
		wait_act(1'b0);
		rd(OFS_STATUS, stat(0, 1, 0), RESP_OKAY);
		bak_run <= 1'b1;
		tick(30);
		$display("test automatic done");
		// Manual edge while both run, held past three slow periods
		manual_sw <= 1'b1;
		wait_act(1'b1);
		mux_follow(1'b1, 24);
		tick(45);
		manual_sw <= 1'b0;
		rd(OFS_STATUS, stat(0, 0, 1), RESP_OKAY);
		tick(45);
		rd(OFS_STATUS, stat(0, 0, 1), RESP_OKAY);
		// Target stops after the edge: the sequencer waits with the gate closed
		manual_sw <= 1'b1;
		pri_run <= 1'b0;
		tick(60);
		rd(OFS_STATUS, stat(1, 0, 1) | 32'h18, RESP_OKAY);
		chk("gated mux", {33'h0, ref_mux}, 34'h0);
		pri_run <= 1'b1;
		wait_act(1'b0);
		manual_sw <= 1'b0;
		tick(10);
		$display("test manual done");
		// Pure manual mode: a falling switch edge leaves the selection alone
		wr(OFS_CTRL, 32'h0);
		manual_sw <= 1'b1;
		wait_act(1'b1);
		tick(45);
		manual_sw <= 1'b0;
		tick(20);
		chk("kept select", {33'h0, act_bak}, 34'h1);
		// New edge in automatic mode, then loss ignored while the switch stays high
		wr(OFS_CTRL, 32'h1);
		manual_sw <= 1'b1;
		wait_act(1'b0);
		pri_run <= 1'b0;
		tick(80);
		rd(OFS_STATUS, stat(1, 0, 0), RESP_OKAY);
		chk("oscillator hold", {33'h0, pfd_en}, 34'h0);
		manual_sw <= 1'b0;
		wait_act(1'b1);
		mux_follow(1'b1, 24);
		pri_run <= 1'b1;
		tick(30);
		$display("test override done");
		// Enable low freezes sensing, so a source stopped meanwhile is not flagged
		ce <= 1'b0;
		pri_run <= 1'b0;
		tick(40);
		chk("frozen lost", {33'h0, pri_lost}, 34'h0);
		chk("frozen select", {33'h0, act_bak}, 34'h1);
		ce <= 1'b1;
		pri_run <= 1'b1;
		tick(20);
		chk("output enable", {33'h0, out_en}, 34'h1);
		chk("switch count", 34'(sw_cnt), 34'h7);
		$display("test enable done");
		if (exp_q.size() != 0)
			hang("drained reads");
		final_report();
	end
endmodule : testbench
